// >>> cmd_pkg.sv
/*
 * constants for the command and register-pointer block of one serial
 * channel. assumes a classic wishbone slave with 32-bit data, byte 0 for commands, bits 9:0 for mask and status.
 */
// Overview of operation
// - crc field 00 idle, 01 resets rx crc checker, 10 resets tx crc generator
// - crc field 11 clears the transmit underrun and end-of-message latch
// - command 100 sets rxNextArmed, held until the next command write
// - command 101 clears the pending transmit interrupt
// - pointer picks registers 0-7, or 8-15 when written with point-high
package cmd_pkg;
    localparam logic [3:0] ADDR_CMD = 4'h0;
    localparam logic [3:0] ADDR_PTR = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    localparam logic [3:0] ADDR_MASK = 4'hC;
    localparam int CRC_MSB = 7;
    localparam int CRC_LSB = 6;
    localparam int CMD_MSB = 5;
    localparam int CMD_LSB = 3;
    localparam int PTR_MSB = 2;
    localparam logic [1:0] CRC_NONE = 2'h0;
    localparam logic [1:0] CRC_RX = 2'h1;
    localparam logic [1:0] CRC_TX = 2'h2;
    localparam logic [1:0] CRC_EOM = 2'h3;
    localparam logic [2:0] CMD_NULL = 3'h0;
    localparam logic [2:0] CMD_HIGH = 3'h1;
    localparam logic [2:0] CMD_EXT = 3'h2;
    localparam logic [2:0] CMD_ABORT = 3'h3;
    localparam logic [2:0] CMD_RXNEXT = 3'h4;
    localparam logic [2:0] CMD_TXINT = 3'h5;
    localparam logic [2:0] CMD_ERR = 3'h6;
    localparam logic [2:0] CMD_IUS = 3'h7;
    localparam int NSTROBE = 10;
    localparam logic [3:0] PTR_RESET = 4'h0;
    localparam logic [9:0] MASK_RESET = 10'h000;
endpackage

// >>> cmd_decode.sv
/*
 * decodes one written command byte into a strobe vector (at most one crc and one command bit set) and pointer.
 * assumes the caller qualifies the result with its own write enable.
 */
`timescale 1ns/1ns
`default_nettype none
module cmd_decode
    import cmd_pkg::*;
(
    input wire logic [7:0] cmdByte,
    output logic [cmd_pkg::NSTROBE-1:0] strobes,
    output logic [3:0] pointer
);
    logic [1:0] crc;
    logic [2:0] cmd;
    always_comb begin
        crc = cmdByte[CRC_MSB:CRC_LSB];
        cmd = cmdByte[CMD_MSB:CMD_LSB];
        strobes = '0;
        // bit order: rxcrc txcrc eom ext abort rxnext txint err ius high
        strobes[0] = (crc == CRC_RX);
        strobes[1] = (crc == CRC_TX);
        strobes[2] = (crc == CRC_EOM);
        strobes[3] = (cmd == CMD_EXT);
        strobes[4] = (cmd == CMD_ABORT);
        strobes[5] = (cmd == CMD_RXNEXT);
        strobes[6] = (cmd == CMD_TXINT);
        strobes[7] = (cmd == CMD_ERR);
        strobes[8] = (cmd == CMD_IUS);
        strobes[9] = (cmd == CMD_HIGH);
        // point high lifts the same codes into the upper bank
        pointer = {cmd == CMD_HIGH, cmdByte[PTR_MSB:0]};
    end
endmodule
`default_nettype wire

// >>> serial_ctrl_command_register.sv
/*
 * command and register-pointer register with wishbone access, strobes to
 * the channel engines and a sticky event status with masked interrupt.
 * assumes engines consume one-cycle strobes on core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl_command_register (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic rxCrcReset,
    output logic txCrcReset,
    output logic eomLatchClear,
    output logic extStatusReset,
    output logic sendAbort,
    output logic errorReset,
    output logic iusReset,
    output logic txIntClear,
    output logic rxNextArmed,
    output logic [3:0] regPointer,
    output logic irq
);
    import cmd_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic [NSTROBE-1:0] decStrobes;
    logic [3:0] decPointer;
    logic [NSTROBE-1:0] status_q;
    logic [NSTROBE-1:0] mask_q;
    logic rxArm_q;
    logic busReq;
    logic cmdWrite;
    cmd_decode u_dec (
        .cmdByte(wb_dat_i[7:0]),
        .strobes(decStrobes),
        .pointer(decPointer)
    );
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmdWrite = busReq && wb_we_i && wb_sel_i[0]
        && wb_adr_i == ADDR_CMD;
    ////////////////////////////////////////////////////////////////////////
    // single wait state: ack one cycle after request, dropped next cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= 32'h0000_0000;
            if (busReq && !wb_we_i) begin
                unique case (wb_adr_i)
                    ADDR_PTR: wb_dat_o <= {28'h0, regPointer};
                    ADDR_STAT: wb_dat_o <= {22'h0, status_q};
                    ADDR_MASK: wb_dat_o <= {22'h0, mask_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command strobes last one cycle; command register itself is write-only
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCrcReset <= 1'b0;
            txCrcReset <= 1'b0;
            eomLatchClear <= 1'b0;
            extStatusReset <= 1'b0;
            sendAbort <= 1'b0;
            txIntClear <= 1'b0;
            errorReset <= 1'b0;
            iusReset <= 1'b0;
        end else begin
            rxCrcReset <= cmdWrite && decStrobes[0];
            txCrcReset <= cmdWrite && decStrobes[1];
            eomLatchClear <= cmdWrite && decStrobes[2];
            extStatusReset <= cmdWrite && decStrobes[3];
            sendAbort <= cmdWrite && decStrobes[4];
            txIntClear <= cmdWrite && decStrobes[6];
            errorReset <= cmdWrite && decStrobes[7];
            iusReset <= cmdWrite && decStrobes[8];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // armed from the cycle after the command write until the next command write;
    // that later write clears it unless it is rxnext again, single-shot
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rxArm_q <= 1'b0;
            rxNextArmed <= 1'b0;
        end else begin
            if (cmdWrite) begin
                rxArm_q <= decStrobes[5];
            end
            rxNextArmed <= cmdWrite ? decStrobes[5] : rxArm_q;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regPointer <= PTR_RESET;
        end else if (cmdWrite) begin
            regPointer <= decPointer;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // sticky status: a read clears; events come only from command writes, so none arrives in a read cycle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            status_q <= '0;
            mask_q <= MASK_RESET;
            irq <= 1'b0;
        end else begin
            if (busReq && !wb_we_i && wb_adr_i == ADDR_STAT) begin
                status_q <= cmdWrite ? decStrobes : '0;
            end else if (cmdWrite) begin
                status_q <= status_q | decStrobes;
            end
            if (busReq && wb_we_i && wb_sel_i[0]
                    && wb_adr_i == ADDR_MASK) begin
                mask_q <= wb_dat_i[NSTROBE-1:0];
            end
            irq <= |(status_q & mask_q);
        end
    end
endmodule
`default_nettype wire

// >>> cmd_reg_checker.sv
/* checker of command strobes and pointer; sees the top ports only */
`timescale 1ns/1ns
`default_nettype none
module cmd_reg_checker
    import cmd_pkg::*;
(
    input wire logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i,
    input wire logic [3:0] wb_adr_i, wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o, rxCrcReset, txCrcReset, eomLatchClear,
    input wire logic sendAbort, txIntClear, rxNextArmed,
    input wire logic [3:0] regPointer
);
    logic [7:0] last_q;
    wire logic wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
        && wb_adr_i == ADDR_CMD && wb_sel_i[0];
    wire logic [1:0] crc = wb_dat_i[7:6];
    wire logic [2:0] cmd = wb_dat_i[5:3];
    always_ff @(posedge core_clk) last_q <= wb_dat_i[7:0];
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_crc_rx: assert property (wr && crc == CRC_RX |=> rxCrcReset)
        else $error("rx crc reset missing");
    a_crc_tx: assert property (wr && crc == CRC_TX |=> txCrcReset)
        else $error("tx crc reset missing");
    a_eom_clear: assert property (wr && crc == CRC_EOM |=> eomLatchClear)
        else $error("eom clear missing");
    a_rx_arm: assert property (wr && cmd == CMD_RXNEXT |=> rxNextArmed)
        else $error("rx next not armed");
    a_rx_once: assert property (rxNextArmed && wr && cmd != CMD_RXNEXT
        |=> !rxNextArmed) else $error("rx next kept");
    a_tx_clear: assert property (wr && cmd == CMD_TXINT |=> txIntClear)
        else $error("tx int clear missing");
    a_ptr_select: assert property (wr |=> regPointer ==
        {last_q[5:3] == CMD_HIGH, last_q[2:0]}) else $error("bad pointer");
    a_abort_send: assert property (wr |=>
        sendAbort == (last_q[5:3] == CMD_ABORT)) else $error("bad abort");
    cover property (wr && cmd == CMD_HIGH);
    cover property (rxNextArmed);
    cover property (wr && crc == CRC_EOM);
endmodule
bind serial_ctrl_command_register cmd_reg_checker chk (.core_clk, .rst_n,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .rxCrcReset, .txCrcReset, .eomLatchClear, .sendAbort,
    .txIntClear, .rxNextArmed, .regPointer);
`default_nettype wire

// >>> wb_host_model.sv
/* wishbone host; classic single cycles on one clock */
`timescale 1ns/1ns
`default_nettype none
module wb_host_model (
    input wire logic clk,
    input wire logic ack,
    input wire logic [31:0] rdat,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [3:0] adr,
    output logic [3:0] sel,
    output logic [31:0] wdat
);
    initial {cyc, stb, we, adr, sel, wdat} = '0;
    // returns at the ack edge, so one-cycle strobes are still seen there;
    // release at that edge keeps cyc and stb low for the following cycle
    task automatic xfer(input logic w, input logic [3:0] a,
            input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        {cyc, stb, we, adr, sel, wdat} <= {2'h3, w, a, 4'h1, 24'h0, d};
        do @(posedge clk); while (ack !== 1'h1);
        r = rdat;
        {cyc, stb, we} <= 3'h0;
    endtask
endmodule
`default_nettype wire

// >>> serial_ctrl_command_register_tb.sv
/* bench for the command register; the host model drives wishbone */
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl_command_register_tb;
    import cmd_pkg::*;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    int err_total = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic cyc, stb, we, ack, irq, rxCrcReset, txCrcReset, eomLatchClear;
    logic extStatusReset, sendAbort, errorReset, iusReset, txIntClear;
    logic rxNextArmed;
    logic [3:0] adr, sel, regPointer;
    logic [31:0] wdat, rdat, r;
    logic [8:0] ev, ex;
    wb_host_model host (.clk(core_clk), .ack, .rdat, .cyc, .stb, .we,
        .adr, .sel, .wdat);
    serial_ctrl_command_register DUT (.core_clk, .rst_n, .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rxCrcReset,
        .txCrcReset, .eomLatchClear, .extStatusReset, .sendAbort,
        .errorReset, .iusReset, .txIntClear, .rxNextArmed, .regPointer,
        .irq);
    initial forever #20 core_clk = ~core_clk;
    task automatic check(input string n, input logic [31:0] s, e);
        samples_checked++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // every crc and command code, one idle cycle apart, pointer swept too
    task automatic testCodes();
        for (int i = 0; i < 8; i++) begin
            host.xfer(1'h1, ADDR_CMD, {i[1:0], i[2:0], 3'(7 - i)}, r);
            ev = {rxCrcReset, txCrcReset, eomLatchClear, extStatusReset,
                sendAbort, errorReset, iusReset, txIntClear, rxNextArmed};
            ex = {i[1:0] == 1, i[1:0] == 2, i[1:0] == 3, i == 2, i == 3,
                i == 6, i == 7, i == 5, i == 4};
            check("strobes", 32'(ev), 32'(ex));
            check("pointer", 32'(regPointer), 32'({i == 1, 3'(7 - i)}));
        end
        host.xfer(1'h1, ADDR_CMD, 8'h0A, r);
        check("pointer high", 32'(regPointer), 32'hA);
        host.xfer(1'h0, ADDR_PTR, 8'h0, r);
        check("pointer read", r, 32'hA);
        $display("codes test done");
    endtask
    task automatic testIrq();
        host.xfer(1'h1, ADDR_MASK, 8'h40, r);
        host.xfer(1'h0, ADDR_MASK, 8'h0, r);
        check("mask read", r, 32'h40);
        host.xfer(1'h0, ADDR_STAT, 8'h0, r);
        host.xfer(1'h1, ADDR_CMD, 8'h28, r);
        host.xfer(1'h0, ADDR_STAT, 8'h0, r);
        check("irq", 32'(irq), 32'h1);
        check("status", r, 32'h40);
        host.xfer(1'h1, ADDR_MASK, 8'h00, r);
        check("irq clear", 32'(irq), 32'h0);
        host.xfer(1'h1, ADDR_CMD, 8'h28, r);
        host.xfer(1'h0, ADDR_STAT, 8'h0, r);
        check("masked irq", 32'(irq), 32'h0);
        check("masked status", r, 32'h40);
        host.xfer(1'h0, 4'h2, 8'h0, r);
        check("unmapped", r, 32'h0);
        host.xfer(1'h0, ADDR_CMD, 8'h0, r);
        check("write only", r, 32'h0);
        $display("irq test done");
    endtask
    initial begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'h1;
        testCodes();
        testIrq();
        report_and_stop();
    end
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_total++;
            report_and_stop();
        end
    end
endmodule
`default_nettype wire
